// *** core/irq_prio_pkg.sv ***
// Constants for the priority level register block: offsets, masks, field positions.
// Assumes a 16-bit register port addressed by register index.
package irq_prio_pkg;

    localparam int          DATA_W      = 16;
    localparam int          CODE_W      = 2;
    localparam int          LEVEL_W     = 2;
    localparam int          NUM_SRC     = 23;

    // Register indices on the address port
    localparam logic [3:0]  TIMER_AB_C_PRIORITY_IDX      = 4'h7;
    localparam logic [3:0]  SERIAL0_TIMER_A_PRIORITY_IDX = 4'h8;
    localparam logic [3:0]  PWM_ADC_PRIORITY_IDX         = 4'h9;

    localparam logic [15:0] TIMER_AB_C_PRIORITY_RST      = 16'h0000;
    localparam logic [15:0] SERIAL0_TIMER_A_PRIORITY_RST = 16'h0000;
    localparam logic [15:0] PWM_ADC_PRIORITY_RST         = 16'h0000;

    // Writable bits; bits 11:10 of the serial register are reserved
    localparam logic [15:0] TIMER_AB_C_PRIORITY_MASK      = 16'hffff;
    localparam logic [15:0] SERIAL0_TIMER_A_PRIORITY_MASK = 16'hf3ff;
    localparam logic [15:0] PWM_ADC_PRIORITY_MASK         = 16'hffff;

    // Field codes
    localparam logic [1:0]  CODE_DISABLED = 2'h0;
    localparam logic [1:0]  CODE_LEVEL0   = 2'h1;
    localparam logic [1:0]  CODE_LEVEL1   = 2'h2;
    localparam logic [1:0]  CODE_LEVEL2   = 2'h3;
    localparam logic [1:0]  LEVEL_0       = 2'h0;
    localparam logic [1:0]  LEVEL_1       = 2'h1;
    localparam logic [1:0]  LEVEL_2       = 2'h2;

    // Field low bit positions, shared by all three registers
    localparam int          FLD_15_14 = 14;
    localparam int          FLD_13_12 = 12;
    localparam int          FLD_11_10 = 10;
    localparam int          FLD_9_8   = 8;
    localparam int          FLD_7_6   = 6;
    localparam int          FLD_5_4   = 4;
    localparam int          FLD_3_2   = 2;
    localparam int          FLD_1_0   = 0;

    // Source numbering on the request and enable vectors
    localparam int          SRC_TMR_A_CH0       = 0;
    localparam int          SRC_TMR_B_CH3       = 1;
    localparam int          SRC_TMR_B_CH2       = 2;
    localparam int          SRC_TMR_B_CH1       = 3;
    localparam int          SRC_TMR_B_CH0       = 4;
    localparam int          SRC_TMR_C_CH3       = 5;
    localparam int          SRC_TMR_C_CH2       = 6;
    localparam int          SRC_TMR_C_CH1       = 7;
    localparam int          SRC_SERIAL0_RX_FULL = 8;
    localparam int          SRC_SERIAL0_RX_ERR  = 9;
    localparam int          SRC_SERIAL0_TX_IDLE = 10;
    localparam int          SRC_SERIAL0_TX_EMPTY = 11;
    localparam int          SRC_TMR_A_CH3       = 12;
    localparam int          SRC_TMR_A_CH2       = 13;
    localparam int          SRC_TMR_A_CH1       = 14;
    localparam int          SRC_PWM_FIRST_FAULT = 15;
    localparam int          SRC_PWM_SECOND_FAULT = 16;
    localparam int          SRC_PWM_FIRST_RELOAD = 17;
    localparam int          SRC_PWM_SECOND_RELOAD = 18;
    localparam int          SRC_CONV_A_ZERO_CROSS = 19;
    localparam int          SRC_CONV_B_ZERO_CROSS = 20;
    localparam int          SRC_CONV_A_DONE     = 21;
    localparam int          SRC_CONV_B_DONE     = 22;

endpackage : irq_prio_pkg

// *** core/prio_field_decode.sv ***
// One two-bit priority field turned into an enable and a level.
// Purely combinational; the caller registers the results.
`timescale 1ns/10ps
module prio_field_decode
    import irq_prio_pkg::*;
(
    input  wire logic [irq_prio_pkg::CODE_W-1:0]  i_code,
    output logic                                  o_en,
    output logic      [irq_prio_pkg::LEVEL_W-1:0] o_level
);
    import irq_prio_pkg::*;

    always_comb begin
        case (i_code)
            CODE_LEVEL0: begin
                o_en    = 1'b1;
                o_level = LEVEL_0;
            end
            CODE_LEVEL1: begin
                o_en    = 1'b1;
                o_level = LEVEL_1;
            end
            CODE_LEVEL2: begin
                o_en    = 1'b1;
                o_level = LEVEL_2;
            end
            default: begin
                // Disabled sources show level 0 so no code can exceed level 2
                o_en    = 1'b0;
                o_level = LEVEL_0;
            end
        endcase
    end

endmodule : prio_field_decode

// *** core/irq_priority_level_regs.sv ***
// Priority level registers for timer, serial, PWM and converter interrupt sources.
// Assumes a single-cycle register port and synchronous peripheral request inputs.
// Summary of operation
// - Code 00 disables a source; 01, 10, 11 give levels 0, 1, 2.
// - No field encoding raises a source above level 2.
// - All fields reset to zero, every source starts disabled.
// - Serial register bits 11:10 read zero and ignore writes.
// - Timer register: timer A ch0 at 15:14, timer B ch3..0 at 13:6.
// - Timer register: timer C ch3, ch2, ch1 at 5:4, 3:2, 1:0.
// - Serial register: receiver full at 15:14, receiver error at 13:12.
// - Serial register: transmitter idle at 9:8, transmitter empty at 7:6.
// - Serial register: timer A ch3, ch2, ch1 at 5:4, 3:2, 1:0.
// - PWM register: first fault at 15:14, second fault at 13:12.
// - PWM register: first reload at 11:10, second reload at 9:8.
// - PWM register low byte: converter zero-cross A, B, then done A, B.
`timescale 1ns/10ps
module irq_priority_level_regs
    import irq_prio_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic                             i_clk,
    input  wire logic                             i_rst_n,
    input  wire logic [ADDR_W-1:0]                i_addr,
    input  wire logic [irq_prio_pkg::DATA_W-1:0]  i_wr_data,
    input  wire logic                             i_wr_en,
    input  wire logic                             i_rd_en,
    output logic      [irq_prio_pkg::DATA_W-1:0]  o_rd_data,
    input  wire logic [irq_prio_pkg::NUM_SRC-1:0] i_src_irq,
    output logic      [irq_prio_pkg::NUM_SRC-1:0] o_src_en,
    output logic      [irq_prio_pkg::NUM_SRC-1:0] o_src_req,
    output logic      [1:0]                       o_tmr_a_ch0_level,
    output logic      [1:0]                       o_tmr_b_ch3_level,
    output logic      [1:0]                       o_tmr_b_ch2_level,
    output logic      [1:0]                       o_tmr_b_ch1_level,
    output logic      [1:0]                       o_tmr_b_ch0_level,
    output logic      [1:0]                       o_tmr_c_ch3_level,
    output logic      [1:0]                       o_tmr_c_ch2_level,
    output logic      [1:0]                       o_tmr_c_ch1_level,
    output logic      [1:0]                       o_serial0_rx_full_level,
    output logic      [1:0]                       o_serial0_rx_error_level,
    output logic      [1:0]                       o_serial0_tx_idle_level,
    output logic      [1:0]                       o_serial0_tx_empty_level,
    output logic      [1:0]                       o_tmr_a_ch3_level,
    output logic      [1:0]                       o_tmr_a_ch2_level,
    output logic      [1:0]                       o_tmr_a_ch1_level,
    output logic      [1:0]                       o_pwm_first_fault_level,
    output logic      [1:0]                       o_pwm_second_fault_level,
    output logic      [1:0]                       o_pwm_first_reload_level,
    output logic      [1:0]                       o_pwm_second_reload_level,
    output logic      [1:0]                       o_conv_a_zero_cross_level,
    output logic      [1:0]                       o_conv_b_zero_cross_level,
    output logic      [1:0]                       o_conv_a_done_level,
    output logic      [1:0]                       o_conv_b_done_level
);
    import irq_prio_pkg::*;

    // Register indices must be reachable on the address port
    if (ADDR_W < 4) begin : g_addr_check
        $error("ADDR_W must be at least 4");
    end

    typedef struct packed {
        logic [DATA_W-1:0]          timer_ab_c_priority_r;
        logic [DATA_W-1:0]          serial0_timer_a_priority_r;
        logic [DATA_W-1:0]          pwm_adc_priority_r;
        logic [DATA_W-1:0]          rd_data_r;
        logic [NUM_SRC-1:0]         src_en_r;
        logic [NUM_SRC-1:0]         src_req_r;
        logic [NUM_SRC*LEVEL_W-1:0] src_level_r;
    } state_type;

    localparam state_type STATE_RST = '{
        timer_ab_c_priority_r:      TIMER_AB_C_PRIORITY_RST,
        serial0_timer_a_priority_r: SERIAL0_TIMER_A_PRIORITY_RST,
        pwm_adc_priority_r:         PWM_ADC_PRIORITY_RST,
        rd_data_r:                  '0,
        src_en_r:                   '0,
        src_req_r:                  '0,
        src_level_r:                '0
    };

    state_type                    st_r;
    state_type                    st_nxt;
    logic [NUM_SRC*CODE_W-1:0]    field_code;
    logic [NUM_SRC-1:0]           dec_en;
    logic [NUM_SRC*LEVEL_W-1:0]   dec_level;
    logic [ADDR_W-1:0]            idx7;
    logic [ADDR_W-1:0]            idx8;
    logic [ADDR_W-1:0]            idx9;

    assign idx7 = ADDR_W'(TIMER_AB_C_PRIORITY_IDX);
    assign idx8 = ADDR_W'(SERIAL0_TIMER_A_PRIORITY_IDX);
    assign idx9 = ADDR_W'(PWM_ADC_PRIORITY_IDX);

    // Gather every field into one vector ordered by source number
    always_comb begin
        field_code = '0;
        field_code[SRC_TMR_A_CH0*CODE_W +: CODE_W] =
            st_r.timer_ab_c_priority_r[FLD_15_14 +: CODE_W];
        field_code[SRC_TMR_B_CH3*CODE_W +: CODE_W] =
            st_r.timer_ab_c_priority_r[FLD_13_12 +: CODE_W];
        field_code[SRC_TMR_B_CH2*CODE_W +: CODE_W] =
            st_r.timer_ab_c_priority_r[FLD_11_10 +: CODE_W];
        field_code[SRC_TMR_B_CH1*CODE_W +: CODE_W] =
            st_r.timer_ab_c_priority_r[FLD_9_8 +: CODE_W];
        field_code[SRC_TMR_B_CH0*CODE_W +: CODE_W] =
            st_r.timer_ab_c_priority_r[FLD_7_6 +: CODE_W];
        field_code[SRC_TMR_C_CH3*CODE_W +: CODE_W] =
            st_r.timer_ab_c_priority_r[FLD_5_4 +: CODE_W];
        field_code[SRC_TMR_C_CH2*CODE_W +: CODE_W] =
            st_r.timer_ab_c_priority_r[FLD_3_2 +: CODE_W];
        field_code[SRC_TMR_C_CH1*CODE_W +: CODE_W] =
            st_r.timer_ab_c_priority_r[FLD_1_0 +: CODE_W];
        field_code[SRC_SERIAL0_RX_FULL*CODE_W +: CODE_W] =
            st_r.serial0_timer_a_priority_r[FLD_15_14 +: CODE_W];
        field_code[SRC_SERIAL0_RX_ERR*CODE_W +: CODE_W] =
            st_r.serial0_timer_a_priority_r[FLD_13_12 +: CODE_W];
        field_code[SRC_SERIAL0_TX_IDLE*CODE_W +: CODE_W] =
            st_r.serial0_timer_a_priority_r[FLD_9_8 +: CODE_W];
        field_code[SRC_SERIAL0_TX_EMPTY*CODE_W +: CODE_W] =
            st_r.serial0_timer_a_priority_r[FLD_7_6 +: CODE_W];
        field_code[SRC_TMR_A_CH3*CODE_W +: CODE_W] =
            st_r.serial0_timer_a_priority_r[FLD_5_4 +: CODE_W];
        field_code[SRC_TMR_A_CH2*CODE_W +: CODE_W] =
            st_r.serial0_timer_a_priority_r[FLD_3_2 +: CODE_W];
        field_code[SRC_TMR_A_CH1*CODE_W +: CODE_W] =
            st_r.serial0_timer_a_priority_r[FLD_1_0 +: CODE_W];
        field_code[SRC_PWM_FIRST_FAULT*CODE_W +: CODE_W] =
            st_r.pwm_adc_priority_r[FLD_15_14 +: CODE_W];
        field_code[SRC_PWM_SECOND_FAULT*CODE_W +: CODE_W] =
            st_r.pwm_adc_priority_r[FLD_13_12 +: CODE_W];
        field_code[SRC_PWM_FIRST_RELOAD*CODE_W +: CODE_W] =
            st_r.pwm_adc_priority_r[FLD_11_10 +: CODE_W];
        field_code[SRC_PWM_SECOND_RELOAD*CODE_W +: CODE_W] =
            st_r.pwm_adc_priority_r[FLD_9_8 +: CODE_W];
        field_code[SRC_CONV_A_ZERO_CROSS*CODE_W +: CODE_W] =
            st_r.pwm_adc_priority_r[FLD_7_6 +: CODE_W];
        field_code[SRC_CONV_B_ZERO_CROSS*CODE_W +: CODE_W] =
            st_r.pwm_adc_priority_r[FLD_5_4 +: CODE_W];
        field_code[SRC_CONV_A_DONE*CODE_W +: CODE_W] =
            st_r.pwm_adc_priority_r[FLD_3_2 +: CODE_W];
        field_code[SRC_CONV_B_DONE*CODE_W +: CODE_W] =
            st_r.pwm_adc_priority_r[FLD_1_0 +: CODE_W];
    end

    for (genvar k = 0; k < NUM_SRC; k++) begin : g_dec
        prio_field_decode u_dec (
            .i_code  (field_code[k*CODE_W +: CODE_W]),
            .o_en    (dec_en[k]),
            .o_level (dec_level[k*LEVEL_W +: LEVEL_W])
        );
    end

    always_comb begin
        st_nxt = st_r;

        // Register writes; masking keeps reserved bits at zero
        if (i_wr_en) begin
            if (i_addr == idx7) begin
                st_nxt.timer_ab_c_priority_r = i_wr_data & TIMER_AB_C_PRIORITY_MASK;
            end else if (i_addr == idx8) begin
                st_nxt.serial0_timer_a_priority_r = i_wr_data & SERIAL0_TIMER_A_PRIORITY_MASK;
            end else if (i_addr == idx9) begin
                st_nxt.pwm_adc_priority_r = i_wr_data & PWM_ADC_PRIORITY_MASK;
            end
        end

        // Read data stands for one cycle only; unmapped indices read zero
        st_nxt.rd_data_r = '0;
        if (i_rd_en) begin
            if (i_addr == idx7) begin
                st_nxt.rd_data_r = st_r.timer_ab_c_priority_r;
            end else if (i_addr == idx8) begin
                st_nxt.rd_data_r = st_r.serial0_timer_a_priority_r & SERIAL0_TIMER_A_PRIORITY_MASK;
            end else if (i_addr == idx9) begin
                st_nxt.rd_data_r = st_r.pwm_adc_priority_r;
            end
        end

        // Decoded view follows stored fields one cycle later
        st_nxt.src_en_r    = dec_en;
        st_nxt.src_level_r = dec_level;
        // Gate with the same decode the enable output takes this edge
        st_nxt.src_req_r   = i_src_irq & dec_en;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rd_data                 = st_r.rd_data_r;
    assign o_src_en                  = st_r.src_en_r;
    assign o_src_req                 = st_r.src_req_r;
    assign o_tmr_a_ch0_level         = st_r.src_level_r[SRC_TMR_A_CH0*LEVEL_W +: LEVEL_W];
    assign o_tmr_b_ch3_level         = st_r.src_level_r[SRC_TMR_B_CH3*LEVEL_W +: LEVEL_W];
    assign o_tmr_b_ch2_level         = st_r.src_level_r[SRC_TMR_B_CH2*LEVEL_W +: LEVEL_W];
    assign o_tmr_b_ch1_level         = st_r.src_level_r[SRC_TMR_B_CH1*LEVEL_W +: LEVEL_W];
    assign o_tmr_b_ch0_level         = st_r.src_level_r[SRC_TMR_B_CH0*LEVEL_W +: LEVEL_W];
    assign o_tmr_c_ch3_level         = st_r.src_level_r[SRC_TMR_C_CH3*LEVEL_W +: LEVEL_W];
    assign o_tmr_c_ch2_level         = st_r.src_level_r[SRC_TMR_C_CH2*LEVEL_W +: LEVEL_W];
    assign o_tmr_c_ch1_level         = st_r.src_level_r[SRC_TMR_C_CH1*LEVEL_W +: LEVEL_W];
    assign o_serial0_rx_full_level   = st_r.src_level_r[SRC_SERIAL0_RX_FULL*LEVEL_W +: LEVEL_W];
    assign o_serial0_rx_error_level  = st_r.src_level_r[SRC_SERIAL0_RX_ERR*LEVEL_W +: LEVEL_W];
    assign o_serial0_tx_idle_level   = st_r.src_level_r[SRC_SERIAL0_TX_IDLE*LEVEL_W +: LEVEL_W];
    assign o_serial0_tx_empty_level  = st_r.src_level_r[SRC_SERIAL0_TX_EMPTY*LEVEL_W +: LEVEL_W];
    assign o_tmr_a_ch3_level         = st_r.src_level_r[SRC_TMR_A_CH3*LEVEL_W +: LEVEL_W];
    assign o_tmr_a_ch2_level         = st_r.src_level_r[SRC_TMR_A_CH2*LEVEL_W +: LEVEL_W];
    assign o_tmr_a_ch1_level         = st_r.src_level_r[SRC_TMR_A_CH1*LEVEL_W +: LEVEL_W];
    assign o_pwm_first_fault_level   = st_r.src_level_r[SRC_PWM_FIRST_FAULT*LEVEL_W +: LEVEL_W];
    assign o_pwm_second_fault_level  = st_r.src_level_r[SRC_PWM_SECOND_FAULT*LEVEL_W +: LEVEL_W];
    assign o_pwm_first_reload_level  = st_r.src_level_r[SRC_PWM_FIRST_RELOAD*LEVEL_W +: LEVEL_W];
    assign o_pwm_second_reload_level = st_r.src_level_r[SRC_PWM_SECOND_RELOAD*LEVEL_W +: LEVEL_W];
    assign o_conv_a_zero_cross_level = st_r.src_level_r[SRC_CONV_A_ZERO_CROSS*LEVEL_W +: LEVEL_W];
    assign o_conv_b_zero_cross_level = st_r.src_level_r[SRC_CONV_B_ZERO_CROSS*LEVEL_W +: LEVEL_W];
    assign o_conv_a_done_level       = st_r.src_level_r[SRC_CONV_A_DONE*LEVEL_W +: LEVEL_W];
    assign o_conv_b_done_level       = st_r.src_level_r[SRC_CONV_B_DONE*LEVEL_W +: LEVEL_W];

endmodule : irq_priority_level_regs

// *** bench/irq_prio_sva.sv ***
// Checker for the priority level register block, watching top-level ports only.
// Assumes one clock domain and register indices 7, 8 and 9.
`timescale 1ns/10ps
module irq_prio_sva #(
    parameter int ADDR_W = 4
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [15:0]       i_wr_data,
    input  wire logic              i_wr_en,
    input  wire logic              i_rd_en,
    input  wire logic [15:0]       o_rd_data,
    input  wire logic [22:0]       i_src_irq,
    input  wire logic [22:0]       o_src_en,
    input  wire logic [22:0]       o_src_req,
    input  wire logic [1:0]        o_tmr_a_ch0_level,
    input  wire logic [1:0]        o_conv_b_done_level
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic [1:0] hi_code = i_wr_data[15:14];
    wire logic [1:0] lo_code = i_wr_data[1:0];
    wire logic       wr7     = i_wr_en && (i_addr == ADDR_W'(7));
    wire logic       wr9     = i_wr_en && (i_addr == ADDR_W'(9));
    function automatic logic [1:0] dec(input logic [1:0] c);
        return (c == 2'h0) ? 2'h0 : c - 2'h1;
    endfunction : dec
    chk_reserved_zero: assert property (i_rd_en && (i_addr == ADDR_W'(8)) |=> o_rd_data[11:10] == 2'h0)
        else $error("reserved bits read nonzero");
    chk_level_cap: assert property (o_tmr_a_ch0_level != 2'h3 && o_conv_b_done_level != 2'h3)
        else $error("level above two");
    chk_req_gated: assert property ((o_src_req & ~o_src_en) == 23'h000000)
        else $error("request from disabled source");
    chk_req_follow: assert property (o_src_req == ($past(i_src_irq) & o_src_en))
        else $error("request not following source");
    chk_a0_decode: assert property (wr7 ##1 !wr7 |=> (o_src_en[0] == |$past(hi_code, 2))
        && (o_tmr_a_ch0_level == dec($past(hi_code, 2)))) else $error("timer a ch0 decode wrong");
    chk_bdone_decode: assert property (wr9 ##1 !wr9 |=> (o_src_en[22] == |$past(lo_code, 2))
        && (o_conv_b_done_level == dec($past(lo_code, 2)))) else $error("converter b done decode wrong");
    chk_dis_level: assert property (!o_src_en[0] |-> o_tmr_a_ch0_level == 2'h0)
        else $error("disabled source shows a level");
    chk_wr_readback: assert property (wr9 ##1 (i_rd_en && i_addr == ADDR_W'(9))
        |=> o_rd_data == $past(i_wr_data, 2)) else $error("read after write mismatch");
    chk_reset_clear: assert property ($rose(i_rst_n) |-> o_src_en == 23'h000000 && o_rd_data == 16'h0000)
        else $error("outputs not clear after reset");
    cover property (wr7 ##1 !wr7);
    cover property (i_rd_en && i_addr == ADDR_W'(8));
    cover property (|o_src_req);
endmodule : irq_prio_sva

bind irq_priority_level_regs irq_prio_sva #(.ADDR_W(ADDR_W)) irq_prio_sva_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_src_irq(i_src_irq), .o_src_en(o_src_en), .o_src_req(o_src_req),
    .o_tmr_a_ch0_level(o_tmr_a_ch0_level), .o_conv_b_done_level(o_conv_b_done_level));

// *** bench/irq_source_model.sv ***
// Peripheral request sources facing the priority register block.
// Assumes the bench sets pattern and mode; lines change only after a rising edge or when reset is asserted.
`timescale 1ns/10ps
module irq_source_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_toggle,
    input  wire logic [22:0] i_pattern,
    output logic      [22:0] o_src_irq
);
    // Toggling exposes gating that lags the request by a cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_src_irq <= 23'h000000;
        end else if (i_toggle) begin
            o_src_irq <= ~o_src_irq;
        end else begin
            o_src_irq <= i_pattern;
        end
    end
endmodule : irq_source_model

// *** bench/tb_irq_priority_level_regs.sv ***
// Self-checking bench for the priority level register block.
// Assumes one-cycle strobes and read data in the cycle after the read.
`timescale 1ns/10ps
module tb_irq_priority_level_regs;
    logic             i_clk       = 1'b0;
    logic             i_rst_n     = 1'b0;
    logic [3:0]       i_addr      = 4'h0;
    logic [15:0]      i_wr_data   = 16'h0000;
    logic             i_wr_en     = 1'b0;
    logic             i_rd_en     = 1'b0;
    logic             src_toggle  = 1'b0;
    logic [22:0]      src_pattern = 23'h000000;
    wire logic [15:0] o_rd_data;
    wire logic [22:0] src_irq;
    wire logic [22:0] o_src_en;
    wire logic [22:0] o_src_req;
    wire logic [1:0]  lv [23];
    logic [15:0]      rdata;
    logic [1:0]       code;
    logic [1:0]       exp_lvl;
    int               num_errors  = 0;
    int               checks      = 0;
    int               cycles      = 0;
    localparam logic [15:0] PATS [4] = '{16'h1b1b, 16'he4e4, 16'h4e4e, 16'hb1b1};
    localparam int    SMAP [3][8] = '{'{0, 1, 2, 3, 4, 5, 6, 7}, '{8, 9, -1, 10, 11, 12, 13, 14},
                                      '{15, 16, 17, 18, 19, 20, 21, 22}};

    irq_priority_level_regs #(.ADDR_W(4)) irq_priority_level_regs_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
        .i_src_irq(src_irq), .o_src_en(o_src_en), .o_src_req(o_src_req),
        .o_tmr_a_ch0_level(lv[0]), .o_tmr_b_ch3_level(lv[1]), .o_tmr_b_ch2_level(lv[2]),
        .o_tmr_b_ch1_level(lv[3]), .o_tmr_b_ch0_level(lv[4]), .o_tmr_c_ch3_level(lv[5]),
        .o_tmr_c_ch2_level(lv[6]), .o_tmr_c_ch1_level(lv[7]), .o_serial0_rx_full_level(lv[8]),
        .o_serial0_rx_error_level(lv[9]), .o_serial0_tx_idle_level(lv[10]), .o_serial0_tx_empty_level(lv[11]),
        .o_tmr_a_ch3_level(lv[12]), .o_tmr_a_ch2_level(lv[13]), .o_tmr_a_ch1_level(lv[14]),
        .o_pwm_first_fault_level(lv[15]), .o_pwm_second_fault_level(lv[16]), .o_pwm_first_reload_level(lv[17]),
        .o_pwm_second_reload_level(lv[18]), .o_conv_a_zero_cross_level(lv[19]),
        .o_conv_b_zero_cross_level(lv[20]), .o_conv_a_done_level(lv[21]), .o_conv_b_done_level(lv[22]));
    irq_source_model irq_source_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_toggle(src_toggle),
        .i_pattern(src_pattern), .o_src_irq(src_irq));

    always #10 i_clk = ~i_clk;

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            $display("Error at %0t: run timed out", $time);
            give_verdict();
        end
    end

    // The write strobe stays up until the next task, so writes can run back to back; rd drops its own strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        i_wr_en   <= 1'b1;
        i_rd_en   <= 1'b0;
        i_addr    <= a;
        i_wr_data <= d;
        @(posedge i_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        i_wr_en <= 1'b0;
        i_rd_en <= 1'b1;
        i_addr  <= a;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        #1 d = o_rd_data;
        @(posedge i_clk);
    endtask : rd
    task automatic idle(input int n);
        i_wr_en <= 1'b0;
        i_rd_en <= 1'b0;
        repeat (n) @(posedge i_clk);
        #1;
    endtask : idle
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_vec(input logic [22:0] got, input logic [22:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: vector %h expected %h", $time, got, exp);
        end
    endtask : chk_vec
    task automatic chk_lvl(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: level %h expected %h", $time, got, exp);
        end
    endtask : chk_lvl

    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        idle(2);
        chk_vec(o_src_en, 23'h000000);
        for (int r = 0; r < 3; r++) begin
            rd(4'(7 + r), rdata);
            chk_word(rdata, 16'h0000);
        end
        $display("test reset_values done");
        for (int r = 0; r < 3; r++) begin
            for (int p = 0; p < 4; p++) begin
                wr(4'(7 + r), PATS[p]);
                idle(1);
                for (int f = 0; f < 8; f++) begin
                    code    = PATS[p][15 - 2 * f -: 2];
                    exp_lvl = (code == 2'h0) ? 2'h0 : code - 2'h1;
                    if (SMAP[r][f] >= 0) begin
                        chk_lvl(lv[SMAP[r][f]], exp_lvl);
                        chk_vec(23'(o_src_en[SMAP[r][f]]), 23'(|code));
                    end
                end
                rd(4'(7 + r), rdata);
                chk_word(rdata, (r == 1) ? (PATS[p] & 16'hf3ff) : PATS[p]);
            end
        end
        $display("test field_map done");
        wr(4'h9, 16'h5a5a);
        rd(4'h9, rdata);
        chk_word(rdata, 16'h5a5a);
        wr(4'h8, 16'hffff);
        wr(4'h3, 16'hffff);
        rd(4'h8, rdata);
        chk_word(rdata, 16'hf3ff);
        rd(4'h3, rdata);
        chk_word(rdata, 16'h0000);
        $display("test bus_edges done");
        wr(4'h7, 16'h0000);
        wr(4'h8, 16'hffff);
        wr(4'h9, 16'h5555);
        src_pattern <= 23'h7fffff;
        idle(3);
        chk_vec(o_src_req, 23'h7fff00);
        src_toggle <= 1'b1;
        idle(5);
        // Lines were high in the last toggled cycle, low now
        chk_vec(o_src_req, 23'h7fff00);
        src_toggle  <= 1'b0;
        src_pattern <= 23'h000000;
        idle(3);
        chk_vec(o_src_req, 23'h000000);
        $display("test requests done");
        i_rst_n <= 1'b0;
        idle(2);
        i_rst_n <= 1'b1;
        idle(1);
        chk_vec(o_src_en, 23'h000000);
        rd(4'h9, rdata);
        chk_word(rdata, 16'h0000);
        $display("test mid_reset done");
        give_verdict();
    end
endmodule : tb_irq_priority_level_regs
